// file: rtl/converter_event_latch_register.sv
// Sticky event register of a converter, reached over the two-wire target.
// Function
// - A set flag stays set after its condition ends until host clears it.
// - Writing one to a bit clears it unless its event lands in that cycle; 0xFF clears every flag but those.
// - Bit 7 sets on entry into over-temperature shutdown.
// - Bit 6 sets when die temperature rises above the 120 C warning.
// - Bit 5 sets on entry into over-current or constant-current limit.
// - Bit 4 sets when constant-current limit returns to voltage regulation.
// - Bit 3 sets when the monitored level drops below undervoltage threshold.
// - Bit 2 sets when over-temperature shutdown ends and operation resumes.
// - Bit 1 sets when die temperature drops below 100 C after warning.
// - Bit 0 sets on each rising edge of power good.
// - Register is reached over the two-wire target at address 60h.
`timescale 1ns/1ps

module converter_event_latch_register
    import event_latch_pkg::*;
#(
    parameter int SYNC_DEPTH = 2
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Two-wire interface pins
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    // Analog condition levels
    input wire monitor_s monitors,
    // Latched flags for the rest of the device
    output logic [7:0] eventFlags
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (SYNC_DEPTH < 2) begin : g_bad_depth
        $error("SYNC_DEPTH must be at least 2");
    end

    function automatic logic isEventReg(input logic [7:0] ptr);
        return ptr == EVENT_REG_ADDR;
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [SYNC_WIDTH-1:0] syncReg [SYNC_DEPTH];
    logic [SYNC_WIDTH-1:0] syncNext [SYNC_DEPTH];
    logic [SYNC_WIDTH-1:0] prevReg;
    logic [SYNC_WIDTH-1:0] prevNext;

    always_comb begin
        syncNext[0] = {scl, sdaIn, monitors};
        for (int i = 1; i < SYNC_DEPTH; i++) begin
            syncNext[i] = syncReg[i-1];
        end
        prevNext = syncReg[SYNC_DEPTH-1];
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < SYNC_DEPTH; i++) begin
                syncReg[i] <= SYNC_RESET;
            end
            prevReg <= SYNC_RESET;
        end else begin
            syncReg <= syncNext;
            prevReg <= prevNext;
        end
    end

    // Only the last stage and its delayed copy are ever looked at
    logic sclS, sdaS, sclP, sdaP;
    monitor_s monS, monP;
    assign sclS = syncReg[SYNC_DEPTH-1][SYNC_SCL];
    assign sdaS = syncReg[SYNC_DEPTH-1][SYNC_SDA];
    assign monS = monitor_s'(syncReg[SYNC_DEPTH-1][4:0]);
    assign sclP = prevReg[SYNC_SCL];
    assign sdaP = prevReg[SYNC_SDA];
    assign monP = monitor_s'(prevReg[4:0]);

    logic sclRise, sclFall, startCond, stopCond;
    assign sclRise = sclS & ~sclP;
    assign sclFall = ~sclS & sclP;
    assign startCond = sclS & sclP & sdaP & ~sdaS;
    assign stopCond = sclS & sclP & ~sdaP & sdaS;

    // ------------------------------------------------------------------
    // Two-wire target
    // ------------------------------------------------------------------
    bus_state_e stateReg, stateNext;
    logic [7:0] shiftReg, shiftNext;
    logic [7:0] ptrReg, ptrNext;
    logic [3:0] bitCntReg, bitCntNext;
    logic readReg, readNext;
    logic sdaOeNReg, sdaOeNNext;
    logic sdaOutReg;
    logic [7:0] clearVec;
    logic [7:0] flagsReg, flagsNext;
    logic [7:0] loadByte;

    assign loadByte = isEventReg(ptrReg) ? flagsReg : UNMAPPED_READ;

    always_comb begin
        stateNext = stateReg;
        shiftNext = shiftReg;
        ptrNext = ptrReg;
        bitCntNext = bitCntReg;
        readNext = readReg;
        sdaOeNNext = sdaOeNReg;
        clearVec = 8'h00;
        if (stopCond) begin
            stateNext = IDLE;
            sdaOeNNext = 1'b1;
        end else if (startCond) begin
            // Repeated start keeps the pointer for a combined read
            stateNext = ADDR;
            bitCntNext = 4'h0;
            sdaOeNNext = 1'b1;
        end else begin
            case (stateReg)
                ADDR, PTR, WR: begin
                    if (sclRise) begin
                        shiftNext = {shiftReg[6:0], sdaS};
                        bitCntNext = bitCntReg + 4'h1;
                    end else if (sclFall && bitCntReg == BITS_PER_BYTE) begin
                        bitCntNext = 4'h0;
                        sdaOeNNext = 1'b0;
                        if (stateReg == ADDR) begin
                            if (shiftReg[7:1] == TARGET_ADDR) begin
                                stateNext = ADDR_ACK;
                                readNext = shiftReg[0];
                            end else begin
                                stateNext = IDLE;
                                sdaOeNNext = 1'b1;
                            end
                        end else if (stateReg == PTR) begin
                            stateNext = PTR_ACK;
                            ptrNext = shiftReg;
                        end else begin
                            stateNext = WR_ACK;
                            ptrNext = ptrReg + 8'h01;
                            if (isEventReg(ptrReg)) begin
                                clearVec = shiftReg;
                            end
                        end
                    end
                end
                ADDR_ACK: begin
                    if (sclFall) begin
                        if (readReg) begin
                            stateNext = RD;
                            shiftNext = loadByte;
                            sdaOeNNext = loadByte[7];
                        end else begin
                            stateNext = PTR;
                            sdaOeNNext = 1'b1;
                        end
                    end
                end
                PTR_ACK, WR_ACK: begin
                    if (sclFall) begin
                        stateNext = WR;
                        sdaOeNNext = 1'b1;
                    end
                end
                RD: begin
                    if (sclFall) begin
                        bitCntNext = bitCntReg + 4'h1;
                        if (bitCntReg == LAST_READ_BIT) begin
                            stateNext = RD_ACK;
                            ptrNext = ptrReg + 8'h01;
                            sdaOeNNext = 1'b1;
                        end else begin
                            shiftNext = {shiftReg[6:0], 1'b0};
                            sdaOeNNext = shiftReg[6];
                        end
                    end
                end
                RD_ACK: begin
                    // Controller NACK ends the read; ACK fetches again
                    if (sclRise && sdaS) begin
                        stateNext = IDLE;
                    end else if (sclFall) begin
                        stateNext = RD;
                        bitCntNext = 4'h0;
                        shiftNext = loadByte;
                        sdaOeNNext = loadByte[7];
                    end
                end
                default: begin
                    stateNext = IDLE;
                    sdaOeNNext = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stateReg <= IDLE;
            shiftReg <= 8'h00;
            ptrReg <= 8'h00;
            bitCntReg <= 4'h0;
            readReg <= 1'b0;
            sdaOeNReg <= 1'b1;
            sdaOutReg <= 1'b0;
        end else begin
            stateReg <= stateNext;
            shiftReg <= shiftNext;
            ptrReg <= ptrNext;
            bitCntReg <= bitCntNext;
            readReg <= readNext;
            sdaOeNReg <= sdaOeNNext;
            sdaOutReg <= 1'b0;
        end
    end

    assign sdaOut = sdaOutReg;
    assign sdaOeN = sdaOeNReg;

    // ------------------------------------------------------------------
    // Event detection and sticky flags
    // ------------------------------------------------------------------
    logic [7:0] setVec;

    always_comb begin
        setVec = 8'h00;
        setVec[BIT_SHUTDOWN_ENTRY] =
            monS.thermalShutdown & ~monP.thermalShutdown;
        setVec[BIT_WARNING_ENTRY] =
            monS.thermalWarning & ~monP.thermalWarning;
        setVec[BIT_LIMIT_ENTRY] =
            monS.currentLimit & ~monP.currentLimit;
        setVec[BIT_LIMIT_RECOVERY] =
            ~monS.currentLimit & monP.currentLimit;
        setVec[BIT_UNDERVOLTAGE_FALL] =
            monS.undervoltage & ~monP.undervoltage;
        setVec[BIT_SHUTDOWN_EXIT] =
            ~monS.thermalShutdown & monP.thermalShutdown;
        setVec[BIT_WARNING_EXIT] =
            ~monS.thermalWarning & monP.thermalWarning;
        setVec[BIT_POWER_GOOD_RISE] =
            monS.powerGood & ~monP.powerGood;
        // Set wins over a clear landing in the same cycle
        flagsNext = (flagsReg & ~clearVec) | setVec;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flagsReg <= FLAGS_RESET;
        end else begin
            flagsReg <= flagsNext;
        end
    end

    assign eventFlags = flagsReg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sticky_hold_a: assert property (
        @(posedge core_clk) disable iff (rst)
        1'b1 |=> ((($past(flagsReg) & ~$past(clearVec)) & ~flagsReg) == 8'h00))
        else $error("flag dropped without a clearing write");

    w1c_clear_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (clearVec != 8'h00) |=>
            ((flagsReg & $past(clearVec) & ~$past(setVec)) == 8'h00))
        else $error("written one did not clear its flag");

    shutdown_entry_a: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(monS.thermalShutdown) |=> flagsReg[BIT_SHUTDOWN_ENTRY])
        else $error("shutdown entry not latched");

    warning_edges_a: assert property (
        @(posedge core_clk) disable iff (rst)
        $changed(monS.thermalWarning) |=>
            ($past(monS.thermalWarning) ? flagsReg[BIT_WARNING_ENTRY]
                                        : flagsReg[BIT_WARNING_EXIT]))
        else $error("warning change not latched");

    limit_flags_a: assert property (
        @(posedge core_clk) disable iff (rst)
        $changed(monS.currentLimit) |=>
            ($past(monS.currentLimit) ? flagsReg[BIT_LIMIT_ENTRY]
                                      : flagsReg[BIT_LIMIT_RECOVERY]))
        else $error("limit change not latched");

    uv_fall_a: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(monS.undervoltage) |=> flagsReg[BIT_UNDERVOLTAGE_FALL])
        else $error("undervoltage fall not latched");

    shutdown_exit_a: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(monS.thermalShutdown) |=> flagsReg[BIT_SHUTDOWN_EXIT])
        else $error("shutdown exit not latched");

    pg_rise_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (monS.powerGood && !monP.powerGood) ##1 1'b1 |->
            flagsReg[BIT_POWER_GOOD_RISE])
        else $error("power good rise not latched");

    addr_ack_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (stateReg == ADDR_ACK) |-> (shiftReg[7:1] == TARGET_ADDR)
            && !sdaOeNReg)
        else $error("acknowledged a foreign address");

    set_wins_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (setVec != 8'h00) |=> ((flagsReg & $past(setVec)) == $past(setVec)))
        else $error("event lost against a clear");

    reset_zero_a: assert property (
        @(posedge core_clk) rst |=> (flagsReg == FLAGS_RESET))
        else $error("flags not zero after reset");

endmodule // converter_event_latch_register

// file: rtl/event_latch_pkg.sv
// Constants and types shared by the converter event latch register.
package event_latch_pkg;

    // ------------------------------------------------------------------
    // Two-wire target address and register map
    // ------------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR = 7'h60;
    localparam logic [7:0] EVENT_REG_ADDR = 8'h0A;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] CLEAR_ALL = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------------
    // Event flag bit positions
    // ------------------------------------------------------------------
    localparam int BIT_SHUTDOWN_ENTRY = 7;
    localparam int BIT_WARNING_ENTRY = 6;
    localparam int BIT_LIMIT_ENTRY = 5;
    localparam int BIT_LIMIT_RECOVERY = 4;
    localparam int BIT_UNDERVOLTAGE_FALL = 3;
    localparam int BIT_SHUTDOWN_EXIT = 2;
    localparam int BIT_WARNING_EXIT = 1;
    localparam int BIT_POWER_GOOD_RISE = 0;

    // ------------------------------------------------------------------
    // Synchroniser layout: {scl, sda, monitors}, idle bus is high
    // ------------------------------------------------------------------
    localparam int SYNC_WIDTH = 7;
    localparam logic [6:0] SYNC_RESET = 7'h60;
    localparam int SYNC_SCL = 6;
    localparam int SYNC_SDA = 5;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_READ_BIT = 4'h7;

    // Analog condition levels, one bit each, asynchronous to core_clk
    typedef struct packed {
        logic thermalShutdown;
        logic thermalWarning;
        logic currentLimit;
        logic undervoltage;
        logic powerGood;
    } monitor_s;

    typedef enum logic [3:0] {
        IDLE, ADDR, ADDR_ACK, PTR, PTR_ACK, WR, WR_ACK, RD, RD_ACK
    } bus_state_e;

endpackage

// file: tb/twowire_host.sv
// Two-wire host model that writes and reads the event register.
`timescale 1ns/1ps

module twowire_host
    import event_latch_pkg::*;
#(
    parameter int HALF = 8
) (
    // Clock
    input wire logic core_clk,
    // Bus wires
    input wire logic sdaWire,
    output logic scl,
    output logic hostOeN
);
    // ------------------------------------------------------------------
    // Bus primitives
    // ------------------------------------------------------------------
    // Phases of HALF clocks stay well above the four-clock minimum
    initial begin
        scl = 1'b1;
        hostOeN = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Data moves only mid-low so it never looks like a start or stop
    task automatic bit_io(input logic b, output logic r);
        wt(HALF / 2);
        hostOeN = b;
        wt(HALF / 2);
        scl = 1'b1;
        wt(HALF);
        r = sdaWire;
        scl = 1'b0;
    endtask

    task automatic start_cond();
        wt(HALF / 2);
        hostOeN = 1'b1;
        wt(HALF / 2);
        scl = 1'b1;
        wt(HALF);
        hostOeN = 1'b0;
        wt(HALF);
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        wt(HALF / 2);
        hostOeN = 1'b0;
        wt(HALF / 2);
        scl = 1'b1;
        wt(HALF);
        hostOeN = 1'b1;
        wt(HALF);
    endtask

    task automatic byte_io(input logic [7:0] d, input logic ackIn,
                           output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ackIn, ack);
    endtask

    // ------------------------------------------------------------------
    // Register transfers
    // ------------------------------------------------------------------
    // Ones in d clear flags; the data byte is the 27th scl fall
    task automatic wr(input logic [6:0] a, input logic [7:0] p, d,
                      output logic nak);
        logic [7:0] q;
        logic k1, k2, k3;
        start_cond();
        byte_io({a, 1'b0}, 1'b1, q, k1);
        byte_io(p, 1'b1, q, k2);
        byte_io(d, 1'b1, q, k3);
        stop_cond();
        nak = k1 | k2 | k3;
    endtask

    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [7:0] q;
        logic k;
        start_cond();
        byte_io({TARGET_ADDR, 1'b0}, 1'b1, q, k);
        byte_io(p, 1'b1, q, k);
        start_cond();
        byte_io({TARGET_ADDR, 1'b1}, 1'b1, q, k);
        byte_io(8'hFF, 1'b1, d, k);
        stop_cond();
    endtask
endmodule // twowire_host

// file: tb/converter_event_latch_register_test.sv
// Self-checking bench for the converter event latch register.
`timescale 1ns/1ps

module converter_event_latch_register_test;
    import event_latch_pkg::*;
    localparam int SD = 2;
    logic core_clk, rst, scl, sdaOut, sdaOeN, hostOeN, sdaWire, nak;
    monitor_s monitors;
    logic [7:0] eventFlags, got, d;
    int bad_count, n_compared, cyc, seedSink;
    logic [7:0] expFlags;

    // Open-drain wire with pull-up
    assign sdaWire = (sdaOeN ? 1'b1 : sdaOut) & hostOeN;

    converter_event_latch_register #(.SYNC_DEPTH(SD)) u_dut (
        .core_clk(core_clk), .rst(rst), .scl(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOeN(sdaOeN), .monitors(monitors),
        .eventFlags(eventFlags));

    twowire_host #(.HALF(8)) u_host (
        .core_clk(core_clk), .sdaWire(sdaWire), .scl(scl),
        .hostOeN(hostOeN));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Ceiling is about three times the expected run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // Model and checking
    // ------------------------------------------------------------------
    function automatic logic [7:0] ev(input logic [4:0] o, n);
        logic [4:0] r, f;
        r = n & ~o;
        f = o & ~n;
        return {r[4], r[3], r[2], f[2], r[1], f[4], f[3], r[0]};
    endfunction

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic set_mon(input logic [4:0] n);
        expFlags |= ev(monitors, n);
        monitors = n;
        wt(SD + 3);
        check(eventFlags, expFlags);
    endtask

    task automatic read_check();
        u_host.rd(EVENT_REG_ADDR, got);
        check(got, expFlags);
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        monitors = '0;
        {bad_count, n_compared, cyc} = '0;
        expFlags = 8'h00;
        seedSink = $urandom(32'h93BE704F);
        wt(16);
        rst = 1'b0;
        wt(4);
        check(eventFlags, FLAGS_RESET);
        read_check();
        $display("Test reset done");
        // Each source rises then falls; flags must outlive conditions
        for (int i = 0; i < 5; i++) begin
            set_mon(5'h01 << i);
            set_mon(5'h00);
        end
        read_check();
        u_host.wr(TARGET_ADDR, EVENT_REG_ADDR, CLEAR_ALL, nak);
        expFlags = 8'h00;
        wt(SD + 3);
        check(eventFlags, expFlags);
        $display("Test sources done");
        for (int i = 0; i < 12; i++) begin
            set_mon(5'($urandom));
            d = 8'($urandom);
            u_host.wr(TARGET_ADDR, EVENT_REG_ADDR, d, nak);
            expFlags &= ~d;
            wt(SD + 3);
            check({7'h00, nak}, 8'h00);
            check(eventFlags, expFlags);
            read_check();
        end
        $display("Test random clear done");
        set_mon(5'h00);
        set_mon(5'h10);
        u_host.wr(7'h61, EVENT_REG_ADDR, CLEAR_ALL, nak);
        check({7'h00, nak}, 8'h01);
        u_host.wr(TARGET_ADDR, 8'h0B, CLEAR_ALL, nak);
        wt(SD + 3);
        check(eventFlags, expFlags);
        u_host.rd(8'h0B, got);
        check(got, UNMAPPED_READ);
        $display("Test refused done");
        // Power good rises as the clearing byte completes
        fork
            u_host.wr(TARGET_ADDR, EVENT_REG_ADDR, CLEAR_ALL, nak);
            begin
                repeat (27) @(negedge scl);
                monitors = monitors | 5'h01;
            end
        join
        wt(SD + 3);
        expFlags = 8'h01;
        check(eventFlags, expFlags);
        read_check();
        $display("Test event at clear done");
        // Reset in mid-run must drop flags that are still pending
        set_mon(5'h00);
        rst = 1'b1;
        wt(SD + 1);
        rst = 1'b0;
        expFlags = 8'h00;
        wt(4);
        check(eventFlags, FLAGS_RESET);
        read_check();
        $display("Test mid reset done");
        report_and_stop();
    end
endmodule // converter_event_latch_register_test
